//--- inc/twb_pkg.sv
// ============================================================
// Shared constants and types of the two-wire bus interface.
package twb_pkg;

  // ============================================================
  // Register offsets on the plain register port.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_CTL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_RXB = 4'h2;
  localparam logic [3:0] OFS_TXB = 4'h3;
  localparam logic [3:0] OFS_OWN = 4'h4;
  localparam logic [3:0] OFS_BRG = 4'h5;
  localparam logic [3:0] OFS_IST = 4'h6;
  localparam logic [3:0] OFS_ICLR = 4'h7;
  localparam logic [3:0] OFS_IEN = 4'h8;

  // ============================================================
  // Control register fields, reset value and implemented bits.
  localparam int CTL_EN = 15;
  localparam int CTL_REL = 12;
  localparam int CTL_ALL = 11;
  localparam int CTL_A10 = 10;
  localparam int CTL_STR = 6;
  localparam logic [15:0] CTL_RST = 16'h1000;
  localparam logic [15:0] CTL_MASK = 16'hBFFF;

  // ============================================================
  // Status fields; bits below ST_OV are read-only.
  localparam int STAT_W = 9;
  localparam int ST_TBF = 0;
  localparam int ST_RBF = 1;
  localparam int ST_RW = 2;
  localparam int ST_S = 3;
  localparam int ST_P = 4;
  localparam int ST_DA = 5;
  localparam int ST_OV = 6;
  localparam int ST_WCOL = 7;
  localparam int ST_TEN = 8;

  // ============================================================
  // Interrupt status bits.
  localparam int IRQ_W = 3;
  localparam int IR_RX = 0;
  localparam int IR_ADR = 1;
  localparam int IR_STOP = 2;

  // ============================================================
  // Protocol constants.
  localparam logic [4:0] TEN_HDR = 5'h1E;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_END = 4'h9;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam logic [1:0] PIN_IDLE = 2'h3;

  // ============================================================
  // Carriers.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } twb_bus_t;

  typedef struct packed {
    logic o;
    logic oe;
  } twb_pin_t;

  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_recv = 6'h02,
    st_ack = 6'h04,
    st_send = 6'h08,
    st_mack = 6'h10,
    st_skip = 6'h20
  } twb_fsm_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
  } twb_sync_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } twb_baud_state_t;

  typedef struct packed {
    logic [15:0] ctl;
    logic [8:0] stat;
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic [9:0] own;
    logic [15:0] brg;
    logic [2:0] ist;
    logic [2:0] ien;
    logic [15:0] rdata;
    logic irq;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    twb_fsm_t fsm;
    logic in_addr;
    logic want_lo;
    logic addressed;
    logic ack_ok;
    logic scl_prev;
    logic sda_prev;
    logic sda_want;
    logic sda_drv;
    twb_pin_t scl;
    twb_pin_t sda;
  } twb_core_state_t;

endpackage

//--- logic/twb_sync.sv
`timescale 1ns/1ps
// ============================================================
// Three-stage synchroniser for both bus pins; a level is taken
// once the second and third stages agree.
module twb_sync
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Raw pin levels.
  input wire logic [1:0] pins,
  // Filtered levels.
  output logic [1:0] lvl
);

  twb_pkg::twb_sync_state_t r;
  twb_pkg::twb_sync_state_t n;

  // Shift the pins through and hold the level until stages agree.
  always_comb
  begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 ^ r.s3));
  end

  // State register; the idle bus reads high.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= {4{twb_pkg::PIN_IDLE}};
    end
    else
    begin
      r <= n;
    end
  end

  assign lvl = r.lvl;

endmodule

//--- logic/twb_baud.sv
`timescale 1ns/1ps
// ============================================================
// Reload counter giving a one-cycle tick every reload+1 cycles.
module twb_baud
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control.
  input wire logic run,
  input wire logic [15:0] reload,
  // Rate enable.
  output logic tick
);

  twb_pkg::twb_baud_state_t r;
  twb_pkg::twb_baud_state_t n;

  // Count down and reload from the reload register at zero.
  always_comb
  begin
    n = r;
    n.tick = 1'b0;
    if (!run)
    begin
      n.cnt = reload;
    end
    else if (r.cnt == 16'h0000)
    begin
      n.cnt = reload;
      n.tick = 1'b1;
    end
    else
    begin
      n.cnt = r.cnt - 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule

//--- logic/twb_core.sv
`timescale 1ns/1ps
// Operation
// - Control register readable and writable except bit 14, which reads zero.
// - Low six status bits are read-only.
// - Full byte moves to buffer unless buffer still full, one interrupt.
// - Transmit holding byte shifted out on reads.
// - Baud reload register reloads rate counter.
// - Own address kept; ten-bit flag shown.
// - Slave holds clock low while release zero.
// - Hardware clears release at transfer boundaries.
// - Select bit picks ten or seven bit address.
// - Accept-all mode acknowledges every address.
// ============================================================
// Register side and slave engine of the two-wire bus module.
module twb_core
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire twb_pkg::twb_bus_t bus,
  output logic [15:0] rdata,
  // Interrupt.
  output logic irq,
  // Bus pins, sensed levels.
  input wire logic scl_i,
  input wire logic sda_i,
  // Port logic drive used while the module is disabled.
  input wire twb_pkg::twb_pin_t port_scl,
  input wire twb_pkg::twb_pin_t port_sda,
  // Bus pin drive.
  output twb_pkg::twb_pin_t scl,
  output twb_pkg::twb_pin_t sda
);

  twb_pkg::twb_core_state_t r;
  twb_pkg::twb_core_state_t n;
  logic [1:0] lvl;
  logic tick;

  // ============================================================
  // Pin synchroniser and baud generator.
  twb_sync u_sync
  (
    .clk(clk),
    .reset_n(reset_n),
    .pins({sda_i, scl_i}),
    .lvl(lvl)
  );

  // The counter reloads from the baud reload register.
  twb_baud u_baud
  (
    .clk(clk),
    .reset_n(reset_n),
    .run(r.ctl[twb_pkg::CTL_EN]),
    .reload(r.brg),
    .tick(tick)
  );

  // ============================================================
  // Next-state logic: register port first, bus events after so
  // that hardware sets win over software in the same cycle.
  always_comb
  begin
    logic en;
    logic s_scl;
    logic s_sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] b;
    logic hi_ok;
    logic [2:0] ev;
    en = r.ctl[twb_pkg::CTL_EN];
    s_scl = lvl[twb_pkg::PIN_SCL];
    s_sda = lvl[twb_pkg::PIN_SDA];
    rise = s_scl & ~r.scl_prev;
    fall = ~s_scl & r.scl_prev;
    start = en & s_scl & r.sda_prev & ~s_sda;
    stop = en & s_scl & ~r.sda_prev & s_sda;
    b = {r.shreg[6:0], s_sda};
    hi_ok = (b[7:3] == twb_pkg::TEN_HDR) & (b[2:1] == r.own[9:8]);
    ev = 3'h0;
    n = r;
    n.scl_prev = s_scl;
    n.sda_prev = s_sda;
    n.rdata = 16'h0000;

    // Register writes.
    if (bus.wr)
    begin
      case (bus.addr)
        twb_pkg::OFS_CTL:
          n.ctl = bus.wdata & twb_pkg::CTL_MASK;
        twb_pkg::OFS_STAT:
          n.stat[twb_pkg::ST_TEN:twb_pkg::ST_OV] =
            bus.wdata[twb_pkg::ST_TEN:twb_pkg::ST_OV];
        twb_pkg::OFS_TXB:
        begin
          n.txbuf = bus.wdata[7:0];
          if (r.stat[twb_pkg::ST_TBF])
          begin
            n.stat[twb_pkg::ST_WCOL] = 1'b1;
          end
          n.stat[twb_pkg::ST_TBF] = 1'b1;
        end
        twb_pkg::OFS_OWN: n.own = bus.wdata[9:0];
        twb_pkg::OFS_BRG: n.brg = bus.wdata;
        twb_pkg::OFS_ICLR: n.ist = r.ist & ~bus.wdata[2:0];
        twb_pkg::OFS_IEN: n.ien = bus.wdata[2:0];
        default: n.ien = n.ien;
      endcase
    end

    // Register reads; a buffer read frees the receive buffer.
    if (bus.rd)
    begin
      case (bus.addr)
        twb_pkg::OFS_CTL: n.rdata = r.ctl;
        twb_pkg::OFS_STAT: n.rdata = 16'(r.stat);
        twb_pkg::OFS_RXB:
        begin
          n.rdata = {8'h00, r.rxbuf};
          n.stat[twb_pkg::ST_RBF] = 1'b0;
        end
        twb_pkg::OFS_TXB: n.rdata = {8'h00, r.txbuf};
        twb_pkg::OFS_OWN: n.rdata = {6'h00, r.own};
        twb_pkg::OFS_BRG: n.rdata = r.brg;
        twb_pkg::OFS_IST: n.rdata = {13'h0000, r.ist};
        twb_pkg::OFS_IEN: n.rdata = {13'h0000, r.ien};
        default: n.rdata = 16'h0000;
      endcase
    end

    // Slave engine.
    if (!en)
    begin
      n.fsm = twb_pkg::st_idle;
      n.addressed = 1'b0;
      n.sda_want = 1'b0;
    end
    else if (stop)
    begin
      n.fsm = twb_pkg::st_idle;
      n.stat[twb_pkg::ST_P] = 1'b1;
      n.stat[twb_pkg::ST_S] = 1'b0;
      n.stat[twb_pkg::ST_TEN] = 1'b0;
      n.addressed = 1'b0;
      n.want_lo = 1'b0;
      n.sda_want = 1'b0;
      ev[twb_pkg::IR_STOP] = 1'b1;
    end
    else if (start)
    begin
      n.fsm = twb_pkg::st_recv;
      n.stat[twb_pkg::ST_S] = 1'b1;
      n.stat[twb_pkg::ST_P] = 1'b0;
      n.stat[twb_pkg::ST_DA] = 1'b0;
      n.bitcnt = 4'h0;
      n.in_addr = 1'b1;
      n.sda_want = 1'b0;
    end
    else
    begin
      case (r.fsm)
        twb_pkg::st_recv:
          if (rise)
          begin
            n.shreg = b;
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == twb_pkg::CNT_LAST)
            begin
              n.fsm = twb_pkg::st_ack;
              if (!r.in_addr)
              begin
                // Assembled byte moves to the buffer unless the buffer is still full.
                n.stat[twb_pkg::ST_DA] = 1'b1;
                ev[twb_pkg::IR_RX] = 1'b1;
                n.ack_ok = ~r.stat[twb_pkg::ST_RBF];
                if (r.stat[twb_pkg::ST_RBF])
                begin
                  n.stat[twb_pkg::ST_OV] = 1'b1;
                end
                else
                begin
                  n.rxbuf = b;
                  n.stat[twb_pkg::ST_RBF] = 1'b1;
                end
                if (r.ctl[twb_pkg::CTL_STR])
                begin
                  n.ctl[twb_pkg::CTL_REL] = 1'b0;
                end
              end
              else if (!r.ctl[twb_pkg::CTL_A10])
              begin
                // Seven-bit compare.
                n.ack_ok = r.ctl[twb_pkg::CTL_ALL] | (b[7:1] == r.own[6:0]);
                n.stat[twb_pkg::ST_RW] = b[0];
                n.in_addr = 1'b0;
                n.addressed = n.ack_ok;
              end
              else if (r.want_lo)
              begin
                // Second byte of a ten-bit address.
                n.ack_ok = r.ctl[twb_pkg::CTL_ALL] | (b == r.own[7:0]);
                n.want_lo = 1'b0;
                n.in_addr = 1'b0;
                n.stat[twb_pkg::ST_RW] = 1'b0;
                n.addressed = n.ack_ok;
                n.stat[twb_pkg::ST_TEN] = n.ack_ok;
              end
              else if (!b[0])
              begin
                n.ack_ok = r.ctl[twb_pkg::CTL_ALL] | hi_ok;
                n.want_lo = n.ack_ok;
              end
              else
              begin
                // Read after repeated start needs the earlier match.
                n.ack_ok = r.ctl[twb_pkg::CTL_ALL] | (hi_ok & r.addressed);
                n.in_addr = 1'b0;
                n.stat[twb_pkg::ST_RW] = 1'b1;
                n.addressed = n.ack_ok;
              end
            end
          end
        twb_pkg::st_ack:
          if (fall && r.bitcnt == twb_pkg::CNT_ACK)
          begin
            n.sda_want = r.ack_ok;
            n.bitcnt = twb_pkg::CNT_END;
            if (r.ack_ok && r.stat[twb_pkg::ST_DA] == 1'b0)
            begin
              ev[twb_pkg::IR_ADR] = ~r.in_addr;
            end
          end
          else if (fall)
          begin
            n.sda_want = 1'b0;
            n.bitcnt = 4'h0;
            if (!r.ack_ok)
            begin
              n.fsm = twb_pkg::st_skip;
            end
            else if (r.stat[twb_pkg::ST_RW] && !r.in_addr)
            begin
              n.fsm = twb_pkg::st_send;
              n.ctl[twb_pkg::CTL_REL] = 1'b0;
            end
            else
            begin
              n.fsm = twb_pkg::st_recv;
            end
          end
        twb_pkg::st_send:
          if (r.bitcnt == 4'h0 && !s_scl)
          begin
            // Hold the first bit from the holding register.
            n.shreg = r.txbuf;
            n.sda_want = ~r.txbuf[7];
          end
          else if (rise)
          begin
            n.bitcnt = r.bitcnt + 4'h1;
            if (r.bitcnt == 4'h0)
            begin
              n.stat[twb_pkg::ST_TBF] = 1'b0;
            end
          end
          else if (fall && r.bitcnt == twb_pkg::CNT_ACK)
          begin
            n.sda_want = 1'b0;
            n.fsm = twb_pkg::st_mack;
          end
          else if (fall)
          begin
            n.shreg = {r.shreg[6:0], 1'b0};
            n.sda_want = ~r.shreg[6];
          end
        twb_pkg::st_mack:
          if (rise && !s_sda)
          begin
            n.fsm = twb_pkg::st_send;
            n.bitcnt = 4'h0;
            n.ctl[twb_pkg::CTL_REL] = 1'b0;
          end
          else if (rise)
          begin
            n.fsm = twb_pkg::st_skip;
          end
        twb_pkg::st_idle: n.sda_want = 1'b0;
        twb_pkg::st_skip: n.sda_want = 1'b0;
        default: n.fsm = twb_pkg::st_idle;
      endcase
    end

    // Interrupt status: set wins over clear, one level output.
    n.ist = n.ist | ev;
    n.irq = |(n.ist & n.ien);

    // Data drive changes on the baud tick for hold time.
    if (tick || !en)
    begin
      n.sda_drv = n.sda_want;
    end

    // Pin ownership follows the enable bit.
    if (en)
    begin
      n.scl.o = 1'b0;
      n.scl.oe = r.addressed & ~r.ctl[twb_pkg::CTL_REL] & ~s_scl &
        (r.fsm != twb_pkg::st_idle) & (r.fsm != twb_pkg::st_skip);
      n.sda.o = 1'b0;
      n.sda.oe = r.sda_drv;
    end
    else
    begin
      n.scl = port_scl;
      n.sda = port_sda;
    end
  end

  // ============================================================
  // State register; release bit, idle state and previous pin levels set, all else clear.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.ctl <= twb_pkg::CTL_RST;
      r.fsm <= twb_pkg::st_idle;
      r.scl_prev <= 1'b1;
      r.sda_prev <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs straight from the state register.
  assign rdata = r.rdata;
  assign irq = r.irq;
  assign scl = r.scl;
  assign sda = r.sda;

endmodule

//--- tb/twb_core_monitor.sv
`timescale 1ns/1ps
// ============================================================
// Port checker of the two-wire bus register block.
module twb_core_monitor
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire twb_pkg::twb_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic irq,
  // Pins.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire twb_pkg::twb_pin_t port_scl,
  input wire twb_pkg::twb_pin_t port_sda,
  input wire twb_pkg::twb_pin_t scl,
  input wire twb_pkg::twb_pin_t sda
);
  logic en_reg;
  logic en_next;
  logic cw;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Follows the module enable from control writes.
  assign cw = bus.wr && bus.addr == twb_pkg::OFS_CTL;
  assign en_next = cw ? bus.wdata[twb_pkg::CTL_EN] : en_reg;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      en_reg <= 1'b0;
    else
      en_reg <= en_next;
  end
  // Register read port.
  a_bit14_zero: assert property (
    bus.rd && bus.addr == twb_pkg::OFS_CTL |=> !rdata[14])
    else $error("control bit 14 read as one");
  a_ctl_back: assert property (
    cw ##2 bus.rd && bus.addr == twb_pkg::OFS_CTL
    |=> (rdata & 16'hAFFF) == ($past(bus.wdata, 3) & 16'hAFFF))
    else $error("control read back differs");
  a_stat_write: assert property (
    bus.wr && bus.addr == twb_pkg::OFS_STAT
    ##2 bus.rd && bus.addr == twb_pkg::OFS_STAT
    |=> (rdata & 16'hFE3F) == 16'h0000)
    else $error("status read-only bits took a write");
  a_baud_back: assert property (
    bus.wr && bus.addr == twb_pkg::OFS_BRG
    ##2 bus.rd && bus.addr == twb_pkg::OFS_BRG
    |=> rdata == $past(bus.wdata, 3))
    else $error("baud reload read back differs");
  // Pin ownership, clock hold and interrupt masking.
  a_port_copy: assert property (
    !en_reg && !$past(en_reg)
    |-> scl == $past(port_scl) && sda == $past(port_sda))
    else $error("disabled pins do not follow port logic");
  a_pins_low: assert property (
    en_reg && $past(en_reg) |-> !scl.o && !sda.o)
    else $error("enabled pins drive high");
  a_release_scl: assert property (
    cw && bus.wdata[15] && bus.wdata[12] |-> ##2 !scl.oe)
    else $error("clock still held after release");
  a_irq_off: assert property (
    bus.wr && bus.addr == twb_pkg::OFS_IEN && bus.wdata[2:0] == 3'h0
    |-> ##2 !irq)
    else $error("interrupt high while all masked");
  // Main scenarios.
  c_rx_read: cover property (bus.rd && bus.addr == twb_pkg::OFS_RXB);
  c_irq: cover property ($rose(irq));
  c_stretch: cover property (en_reg && scl.oe && !scl_i);
endmodule
bind twb_core twb_core_monitor u_mon
(
  .clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .irq(irq),
  .scl_i(scl_i), .sda_i(sda_i), .port_scl(port_scl),
  .port_sda(port_sda), .scl(scl), .sda(sda)
);

//--- tb/twb_master_model.sv
`timescale 1ns/1ps
// ============================================================
// Bus master on the far side; it only pulls lines low.
module twb_master_model
(
  // Clock.
  input wire logic clk,
  // Resolved line levels.
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables.
  output logic scl_lo,
  output logic sda_lo
);
  localparam int HALF = 20;
  // Bits sampled on the eight data clocks of the latest byte.
  logic [7:0] rx;
  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // Waits n clock cycles.
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Lets the clock rise, waiting out a stretching slave.
  task automatic rise(output logic ok);
    scl_lo <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 400 && ok !== 1'b1; i++)
    begin
      @(posedge clk);
      ok = scl;
    end
    gap(HALF);
  endtask
  // Start: data falls while the clock is high.
  task automatic start();
    sda_lo <= 1'b1;
    gap(HALF);
    scl_lo <= 1'b1;
    gap(8);
  endtask
  // Eight bits, most significant first, then the acknowledge clock.
  task automatic put_byte(input logic [7:0] d, output logic ack,
      output logic ok);
    logic r;
    ok = 1'b1;
    for (int j = 0; j < 9; j++)
    begin
      sda_lo <= (j < 8) && !d[7 - j];
      gap(HALF);
      rise(r);
      ok = ok & r;
      ack = sda;
      if (j < 8)
        rx = {rx[6:0], sda};
      scl_lo <= 1'b1;
      gap(8);
    end
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    logic r;
    sda_lo <= 1'b1;
    gap(HALF);
    rise(r);
    sda_lo <= 1'b0;
    gap(HALF);
  endtask
endmodule

//--- tb/test_twb_core.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the two-wire bus register block.
module test_twb_core;
  logic clk, reset_n, irq, scl_i, sda_i, m_scl_lo, m_sda_lo;
  logic ack, ok, done;
  twb_pkg::twb_bus_t bus;
  twb_pkg::twb_pin_t port_scl, port_sda, scl, sda;
  logic [15:0] rdata, lfsr, got;
  logic [6:0] own7;
  logic [3:0] ra [5];
  int n_fail, samples_checked, n_str, i;
  // Open-drain lines with pull-ups.
  assign scl_i = (scl.oe ? scl.o : 1'b1) & ~m_scl_lo;
  assign sda_i = (sda.oe ? sda.o : 1'b1) & ~m_sda_lo;
  twb_core u_dut (.clk(clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .irq(irq), .scl_i(scl_i), .sda_i(sda_i),
    .port_scl(port_scl), .port_sda(port_sda), .scl(scl), .sda(sda));
  twb_master_model u_master (.clk(clk), .scl(scl_i), .sda(sda_i),
    .scl_lo(m_scl_lo), .sda_lo(m_sda_lo));
  // Clock of 100 ns.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Stimulus shift register step.
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Expected read back after writing d.
  function automatic logic [15:0] rb_exp(input logic [3:0] a,
      input logic [15:0] d);
    case (a)
      twb_pkg::OFS_CTL: return d & 16'hBFFF;
      twb_pkg::OFS_STAT: return {7'h00, d[8:6], 6'h00};
      twb_pkg::OFS_TXB: return {8'h00, d[7:0]};
      twb_pkg::OFS_OWN: return {6'h00, d[9:0]};
      default: return d;
    endcase
  endfunction
  // Compares and counts.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One clock, then let its updates land.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Register write and read cycles.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick();
    bus.wr <= 1'b0;
    tick();
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    tick();
    bus.rd <= 1'b0;
    q = rdata;
    tick();
  endtask
  // Address byte, data byte if acknowledged, stop; checks receipt.
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
      input logic nack);
    u_master.start();
    u_master.put_byte(a, ack, ok);
    check(16'(ack), 16'(nack));
    if (!ack)
      u_master.put_byte(d, ack, ok);
    u_master.stop();
    if (!nack)
    begin
      check(16'(irq), 16'h0001);
      rd(twb_pkg::OFS_RXB, got);
      check(got, 16'(d));
    end
  endtask
  // Verdict.
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Cuts a hung run short.
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    conclude();
  end
  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    bus = '0;
    port_scl = '0;
    port_sda = '0;
    n_fail = 0;
    samples_checked = 0;
    lfsr = 16'h002E;
    ra = '{twb_pkg::OFS_STAT, twb_pkg::OFS_TXB, twb_pkg::OFS_OWN,
      twb_pkg::OFS_BRG, twb_pkg::OFS_CTL};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tick();
    // Reset values over the whole map except offset 7, unmapped places included.
    for (i = 0; i < 16; i++)
      if (i != 7)
      begin
        rd(4'(i), got);
        check(got, i == 0 ? 16'h1000 : 16'h0000);
      end
    // Random write and read back; pins follow port logic when off.
    for (i = 0; i < 20; i++)
    begin
      lfsr = nxt(lfsr);
      port_scl <= lfsr[1:0];
      port_sda <= lfsr[3:2];
      wr(ra[i / 4], lfsr);
      rd(ra[i / 4], got);
      check(got, rb_exp(ra[i / 4], lfsr));
      if (ra[i / 4] == twb_pkg::OFS_CTL && lfsr[15])
        check(16'({scl.o, sda.o}), 16'h0000);
      else if (ra[i / 4] == twb_pkg::OFS_CTL)
        check(16'({scl, sda}), 16'({port_scl, port_sda}));
    end
    // Seven-bit slave: own address, foreign address, accept-all.
    port_scl <= '0;
    port_sda <= '0;
    own7 = lfsr[6:0];
    wr(twb_pkg::OFS_OWN, 16'(own7));
    wr(twb_pkg::OFS_BRG, 16'h0002);
    wr(twb_pkg::OFS_IEN, 16'h0007);
    for (i = 0; i < 4; i++)
    begin
      wr(twb_pkg::OFS_CTL, i[0] ? 16'h9800 : 16'h9000);
      wr(twb_pkg::OFS_ICLR, 16'h0007);
      lfsr = nxt(lfsr);
      xfer({own7 ^ {6'h00, i[1]}, 1'b0}, lfsr[7:0], i[1] & !i[0]);
    end
    // Masking and clearing the interrupt.
    wr(twb_pkg::OFS_IEN, 16'h0000);
    check(16'(irq), 16'h0000);
    wr(twb_pkg::OFS_IEN, 16'h0007);
    check(16'(irq), 16'h0001);
    wr(twb_pkg::OFS_ICLR, 16'h0007);
    check(16'(irq), 16'h0000);
    // Ten-bit own address: header byte, low byte, then data.
    wr(twb_pkg::OFS_OWN, {6'h00, lfsr[9:0]});
    wr(twb_pkg::OFS_CTL, 16'h9400);
    u_master.start();
    u_master.put_byte({twb_pkg::TEN_HDR, lfsr[9:8], 1'b0}, ack, ok);
    check(16'(ack), 16'h0000);
    u_master.put_byte(lfsr[7:0], ack, ok);
    check(16'(ack), 16'h0000);
    rd(twb_pkg::OFS_STAT, got);
    check(16'(got[twb_pkg::ST_TEN]), 16'h0001);
    u_master.put_byte(lfsr[15:8], ack, ok);
    u_master.stop();
    rd(twb_pkg::OFS_RXB, got);
    check(got, {8'h00, lfsr[15:8]});
    // Stretching: hardware clears release, clock stays low until set.
    // A slave read follows, shifting out the holding byte.
    wr(twb_pkg::OFS_OWN, 16'(own7));
    lfsr = nxt(lfsr);
    wr(twb_pkg::OFS_TXB, {8'h00, lfsr[7:0]});
    wr(twb_pkg::OFS_CTL, 16'h9040);
    done = 1'b0;
    n_str = 0;
    fork
      begin
        u_master.start();
        u_master.put_byte({own7, 1'b0}, ack, ok);
        u_master.put_byte(8'hA5, ack, ok);
        u_master.stop();
        u_master.start();
        u_master.put_byte({own7, 1'b1}, ack, ok);
        u_master.put_byte(8'hFF, ack, ok);
        u_master.stop();
        done = 1'b1;
      end
      while (!done)
      begin
        rd(twb_pkg::OFS_CTL, got);
        if (!got[12] && !done)
        begin
          repeat (80) tick();
          check(16'({scl_i, scl.oe}), 16'h0001);
          n_str++;
          wr(twb_pkg::OFS_CTL, 16'h9040);
        end
      end
    join
    check(16'(ok), 16'h0001);
    check(16'(u_master.rx), {8'h00, lfsr[7:0]});
    check(16'(n_str > 0), 16'h0001);
    rd(twb_pkg::OFS_RXB, got);
    check(got, 16'h00A5);
    conclude();
  end
endmodule
